// *** src/ssl_pkg.sv ***
// Constants and types shared by the strap setpoint loader.
`default_nettype none
package ssl_pkg;

    // ****************************************************************
    // Strap pin states: bit 1 marks a resistor, bit 0 a high level.
    // ****************************************************************
    localparam logic [1:0] STRAP_GND     = 2'h0;
    localparam logic [1:0] STRAP_VIN     = 2'h1;
    localparam logic [1:0] STRAP_RES_GND = 2'h2;
    localparam logic [1:0] STRAP_RES_VIN = 2'h3;
    localparam int         STRAP_RES_BIT = 1;
    localparam int         STRAP_HI_BIT  = 0;

    // ****************************************************************
    // Target addresses and range codes.
    // ****************************************************************
    localparam logic [6:0] ADDR_0 = 7'h40;
    localparam logic [6:0] ADDR_1 = 7'h41;
    localparam logic [6:0] ADDR_2 = 7'h42;
    localparam logic [6:0] ADDR_3 = 7'h43;
    localparam logic [6:0] ADDR_4 = 7'h44;
    // Range 2: 0.4 V to 1.675 V in 5 mV. Range 3: 0.8 V to 3.35 V in 10 mV.
    localparam logic [1:0] RANGE_5MV  = 2'h2;
    localparam logic [1:0] RANGE_10MV = 2'h3;

    // ****************************************************************
    // Reset values of the host-visible fields.
    // ****************************************************************
    localparam logic [1:0] SSTIME_RESET = 2'h1;
    localparam logic [1:0] SLEW_RESET   = 2'h2;
    localparam logic [7:0] CODE_RESET   = 8'h00;
    localparam logic [6:0] ADDR_RESET   = ADDR_0;
    localparam logic [1:0] RANGE_RESET  = RANGE_10MV;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int INIT_SETTLE_NS = 100;
    localparam int INIT_CYCLES    =
        (INIT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_INIT,
        ST_OFF,
        ST_SOFT,
        ST_RUN
    } ssl_state_t;

endpackage
`default_nettype wire

// *** src/ssl_loader.sv ***
// Strap sampling, address and default load, and setpoint write gating.
`default_nettype none
module ssl_loader #(
    parameter int INIT_WAIT = ssl_pkg::INIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [1:0] strap_pin_a,
    input  wire logic [1:0] strap_pin_b,
    input  wire logic [1:0] strap_pin_c,
    input  wire logic       en_in,
    output logic            en_out,
    output logic            en_oe,
    input  wire logic       soft_reset_req,
    input  wire logic       wr_setpoint,
    input  wire logic [7:0] wr_setpoint_data,
    input  wire logic       wr_range,
    input  wire logic [1:0] wr_range_data,
    input  wire logic       wr_sstime,
    input  wire logic [1:0] wr_sstime_data,
    input  wire logic       wr_slew,
    input  wire logic [1:0] wr_slew_data,
    input  wire logic       soft_start_done,
    output logic            host_ready,
    output logic [6:0]      target_addr,
    output logic [7:0]      setpoint_register_code,
    output logic [1:0]      voltage_range_field,
    output logic [1:0]      soft_start_time_field,
    output logic [1:0]      slew_rate_field,
    output logic [7:0]      applied_code,
    output logic [1:0]      applied_range,
    output logic [1:0]      applied_sstime,
    output logic [1:0]      applied_slew,
    output logic            soft_start_active,
    output logic            converter_on
);
    import ssl_pkg::*;

    if (INIT_WAIT < 4 || INIT_WAIT > 255) begin : g_bad_wait
        $error("INIT_WAIT must lie in 4 to 255");
    end

    // ****************************************************************
    // Pin synchronisers: a change counts once stages two and three agree.
    // ****************************************************************
    logic [6:0] pin_s1_reg;
    logic [6:0] pin_s2_reg;
    logic [6:0] pin_s3_reg;
    logic [6:0] pin_reg;
    logic [6:0] pin_next;
    logic [6:0] pin_raw;
    logic [6:0] pin_differ;

    assign pin_raw    = {en_in, strap_pin_c, strap_pin_b, strap_pin_a};
    assign pin_differ = pin_s2_reg ^ pin_s3_reg;
    assign pin_next   = (~pin_differ & pin_s2_reg) | (pin_differ & pin_reg);

    always_ff @(posedge clk) begin
        pin_s1_reg <= pin_raw;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        if (reset) begin
            pin_reg <= 7'h00;
        end else begin
            pin_reg <= pin_next;
        end
    end

    logic       en_level;
    logic [2:0] res_bits;
    logic [2:0] hi_bits;
    assign en_level = pin_reg[6];
    assign res_bits = {pin_reg[4 + STRAP_RES_BIT], pin_reg[2 + STRAP_RES_BIT],
                       pin_reg[STRAP_RES_BIT]};
    assign hi_bits  = {pin_reg[4 + STRAP_HI_BIT], pin_reg[2 + STRAP_HI_BIT],
                       pin_reg[STRAP_HI_BIT]};

    // ****************************************************************
    // Strap decode: a step index in 50 mV from 0.45 V, then the code.
    // ****************************************************************
    logic [5:0] step_base;
    logic [6:0] dec_addr;
    logic [1:0] dec_range;
    logic [7:0] dec_code;
    logic [5:0] step_idx;

    always_comb begin
        case (res_bits)
            3'b000: begin step_base = 6'h3f; dec_addr = ADDR_0; end
            3'b100: begin step_base = 6'h07; dec_addr = ADDR_1; end
            3'b010: begin step_base = 6'h0f; dec_addr = ADDR_2; end
            3'b001: begin step_base = 6'h17; dec_addr = ADDR_3; end
            3'b110: begin step_base = 6'h1f; dec_addr = ADDR_0; end
            3'b101: begin step_base = 6'h27; dec_addr = ADDR_1; end
            3'b011: begin step_base = 6'h2f; dec_addr = ADDR_2; end
            3'b111: begin step_base = 6'h37; dec_addr = ADDR_3; end
            default: begin step_base = 6'h00; dec_addr = ADDR_0; end
        endcase
        step_idx = 6'(step_base + {3'h0, hi_bits});
        if (res_bits == 3'b000) begin
            dec_range = RANGE_5MV;
            dec_code  = 8'(step_idx * 10 + 10);
        end else begin
            dec_range = RANGE_10MV;
            dec_code  = 8'(step_idx * 5 - 35);
        end
        if (res_bits == 3'b000 && hi_bits == 3'h0) begin
            dec_range = RANGE_10MV;
            dec_code  = 8'h00;
        end
        if (res_bits == 3'b111 && hi_bits[2]) begin
            dec_addr = ADDR_4;
            case (hi_bits[1:0])
                2'h0: begin dec_range = RANGE_5MV;  dec_code = 8'h46; end
                2'h1: begin dec_range = RANGE_10MV; dec_code = 8'h19; end
                2'h2: begin dec_range = RANGE_10MV; dec_code = 8'h1e; end
                2'h3: begin dec_range = RANGE_10MV; dec_code = 8'h28; end
                default: begin dec_range = RANGE_10MV; dec_code = 8'h00; end
            endcase
        end
    end

    // ****************************************************************
    // Sequencer.
    // ****************************************************************
    ssl_state_t state_reg;
    ssl_state_t state_next;
    logic [7:0] wait_reg;
    logic       en_last_reg;
    logic       load_now;
    logic       en_rise;
    logic       restart;
    logic       host_ok;

    assign load_now = state_reg == ST_INIT && wait_reg == 8'(INIT_WAIT - 1);
    assign en_rise  = en_level && !en_last_reg;
    assign host_ok  = state_reg != ST_INIT;
    assign restart  = host_ok && soft_reset_req;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_INIT: if (load_now) state_next = ST_OFF;
            ST_OFF:  if (en_rise) state_next = ST_SOFT;
            ST_SOFT: begin
                if (!en_level) begin
                    state_next = ST_OFF;
                end else if (soft_start_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN:  if (!en_level) state_next = ST_OFF;
            default: state_next = ST_INIT;
        endcase
        if (restart) begin
            state_next = ST_INIT;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || restart) begin
            state_reg   <= ST_INIT;
            wait_reg    <= 8'h00;
            en_last_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            wait_reg    <= load_now ? wait_reg : wait_reg + 8'h01;
            en_last_reg <= state_reg == ST_INIT ? 1'b0 : en_level;
        end
    end

    // ****************************************************************
    // Host-visible fields; strap defaults load together in one edge.
    // ****************************************************************
    logic [1:0] range_commit_reg;
    logic [1:0] range_new;
    assign range_new = wr_range ? wr_range_data : voltage_range_field;

    always_ff @(posedge clk) begin
        if (reset || restart) begin
            target_addr            <= ADDR_RESET;
            setpoint_register_code <= CODE_RESET;
            voltage_range_field    <= RANGE_RESET;
            range_commit_reg       <= RANGE_RESET;
            soft_start_time_field  <= SSTIME_RESET;
            slew_rate_field        <= SLEW_RESET;
        end else if (load_now) begin
            target_addr            <= dec_addr;
            setpoint_register_code <= dec_code;
            voltage_range_field    <= dec_range;
            range_commit_reg       <= dec_range;
        end else if (host_ok) begin
            if (wr_setpoint) begin
                setpoint_register_code <= wr_setpoint_data;
                range_commit_reg       <= range_new;
            end
            if (wr_range) voltage_range_field <= wr_range_data;
            if (wr_sstime) soft_start_time_field <= wr_sstime_data;
            if (wr_slew) slew_rate_field <= wr_slew_data;
        end
    end

    // ****************************************************************
    // Values handed to the converter.
    // ****************************************************************
    logic take_now;
    assign take_now = (state_reg == ST_OFF && en_rise)
                   || (state_reg == ST_SOFT && soft_start_done && en_level)
                   || state_reg == ST_RUN;

    always_ff @(posedge clk) begin
        if (reset || restart) begin
            applied_code   <= CODE_RESET;
            applied_range  <= RANGE_RESET;
            applied_sstime <= SSTIME_RESET;
            applied_slew   <= SLEW_RESET;
        end else if (take_now) begin
            applied_code   <= setpoint_register_code;
            applied_range  <= range_commit_reg;
            applied_slew   <= slew_rate_field;
            if (state_reg == ST_OFF) begin
                applied_sstime <= soft_start_time_field;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            en_out            <= 1'b0;
            en_oe             <= 1'b1;
            host_ready        <= 1'b0;
            soft_start_active <= 1'b0;
            converter_on      <= 1'b0;
        end else begin
            en_out            <= 1'b0;
            en_oe             <= state_next == ST_INIT;
            host_ready        <= state_next != ST_INIT;
            soft_start_active <= state_next == ST_SOFT;
            converter_on      <= state_next == ST_SOFT
                              || state_next == ST_RUN;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_en_start;
        state_reg == ST_OFF && en_rise && !restart;
    endsequence

    sequence s_ramp_end;
        state_reg == ST_SOFT && soft_start_done && en_level && !restart;
    endsequence

    a_init_holds_en: assert property (
        state_reg == ST_INIT && !load_now |=> en_oe && !host_ready)
        else $error("enable released or host open during init");
    a_addr_steady: assert property (
        !load_now && !restart |=> $stable(target_addr))
        else $error("address changed without a sampling event");
    a_load_whole: assert property (
        load_now && !restart |=> target_addr == $past(dec_addr)
        && setpoint_register_code == $past(dec_code)
        && voltage_range_field == $past(dec_range))
        else $error("strap defaults not loaded together");
    a_reset_resamples: assert property (
        restart |=> state_reg == ST_INIT ##(INIT_WAIT) state_reg == ST_OFF)
        else $error("reset bit did not resample the straps");
    a_ramp_holds: assert property (
        state_reg == ST_SOFT && !soft_start_done && !restart
        |=> $stable(applied_code) && $stable(applied_range)
        && $stable(applied_sstime))
        else $error("applied value moved during soft start");
    a_enable_applies: assert property (
        s_en_start |=> applied_code == $past(setpoint_register_code)
        && applied_sstime == $past(soft_start_time_field)
        && soft_start_active)
        else $error("stored value not applied at enable");
    a_ramp_end_moves: assert property (
        s_ramp_end |=> applied_code == $past(setpoint_register_code)
        && !soft_start_active && converter_on)
        else $error("programmed value not taken after soft start");
    a_range_waits: assert property (
        wr_range && !wr_setpoint && !load_now && !restart
        |=> $stable(range_commit_reg))
        else $error("range adopted without a setpoint write");
    a_addr_legal: assert property (
        host_ready |-> target_addr >= ADDR_0 && target_addr <= ADDR_4)
        else $error("address outside the legal set");

endmodule
`default_nettype wire

// *** tb/ssl_board.sv ***
// Board model: strap pins and the shared open-drain enable line.
`default_nettype none
module ssl_board (
    input  wire logic [5:0] strap_set,
    input  wire logic       ext_en,
    input  wire logic       en_out,
    input  wire logic       en_oe,
    output logic [1:0]      strap_pin_a,
    output logic [1:0]      strap_pin_b,
    output logic [1:0]      strap_pin_c,
    output logic            en_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin c is the most significant pair of the strap setting.
    assign strap_pin_c = strap_set[5:4];
    assign strap_pin_b = strap_set[3:2];
    assign strap_pin_a = strap_set[1:0];
    // The device pull-down wins over the external enable driver.
    assign en_in = en_oe ? en_out : ext_en;
endmodule
`default_nettype wire

// *** tb/tb_ssl_loader.sv ***
// Testbench for the strap setpoint loader.
`default_nettype none
module tb_ssl_loader;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [5:0] strap_set = 6'h00;
    logic       ext_en = 1'b0;
    logic       soft_reset_req = 1'b0;
    logic [3:0] wr_stb = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic       soft_start_done = 1'b0;
    logic [1:0] pin_a, pin_b, pin_c;
    logic       en_in, en_out, en_oe, host_ready;
    logic [6:0] target_addr;
    logic [7:0] sp_code, ap_code;
    logic [1:0] rng, sst, slw, ap_rng, ap_sst, ap_slw;
    logic       ss_active, converter_on;
    int         mismatches = 0;
    int         comparisons = 0;
    logic [5:0] st [12] = '{6'h01, 6'h15, 6'h20, 6'h08, 6'h02, 6'h2f,
                            6'h3a, 6'h00, 6'h3f, 6'h3b, 6'h3e, 6'h28};
    logic [6:0] ad [12] = '{7'h40, 7'h40, 7'h41, 7'h42, 7'h43, 7'h43,
                            7'h44, 7'h40, 7'h44, 7'h44, 7'h44, 7'h40};
    logic [1:0] rg [12] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3,
                            2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
    logic [7:0] cd [12] = '{8'h0a, 8'h46, 8'h00, 8'h28, 8'h50, 8'hff,
                            8'h46, 8'h00, 8'h28, 8'h19, 8'h1e, 8'h78};

    always #5 clk = ~clk;

    ssl_board ssl_board_i (.strap_set(strap_set), .ext_en(ext_en),
        .en_out(en_out), .en_oe(en_oe), .strap_pin_a(pin_a),
        .strap_pin_b(pin_b), .strap_pin_c(pin_c), .en_in(en_in));

    ssl_loader #(.INIT_WAIT(4)) ssl_loader_i (.clk(clk), .reset(reset),
        .strap_pin_a(pin_a), .strap_pin_b(pin_b), .strap_pin_c(pin_c),
        .en_in(en_in), .en_out(en_out), .en_oe(en_oe),
        .soft_reset_req(soft_reset_req),
        .wr_setpoint(wr_stb[0]), .wr_setpoint_data(wr_data),
        .wr_range(wr_stb[1]), .wr_range_data(wr_data[1:0]),
        .wr_sstime(wr_stb[2]), .wr_sstime_data(wr_data[1:0]),
        .wr_slew(wr_stb[3]), .wr_slew_data(wr_data[1:0]),
        .soft_start_done(soft_start_done), .host_ready(host_ready),
        .target_addr(target_addr), .setpoint_register_code(sp_code),
        .voltage_range_field(rng), .soft_start_time_field(sst),
        .slew_rate_field(slw), .applied_code(ap_code),
        .applied_range(ap_rng), .applied_sstime(ap_sst),
        .applied_slew(ap_slw), .soft_start_active(ss_active),
        .converter_on(converter_on));

    // ****************************************************************
    // Tasks.
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Writes one host field: 0 setpoint, 1 range, 2 soft-start, 3 slew.
    task automatic wr(input int k, input logic [7:0] d);
        wr_data = d;
        wr_stb = 4'h1 << k;
        tick(1);
        wr_stb = 4'h0;
        tick(1);
    endtask

    task automatic wait_on(input int sel, input logic v);
        for (int n = 0; n < 20; n++) begin
            if ((sel == 0 ? host_ready : converter_on) === v) return;
            tick(1);
        end
        mismatches++;
        $display("FAIL wait%0d expected %b seen %b", sel, v, ~v);
    endtask

    task automatic boot(input int i);
        strap_set = st[i];
        reset = 1'b1;
        tick(5);
        reset = 1'b0;
        wr(3, 8'h03);
        chk("init_hold", 8'h02, 8'({en_oe, host_ready}));
        wait_on(0, 1'b1);
        chk("en_release", 8'h00, 8'(en_oe));
        chk("en_drive", 8'h00, 8'(en_out));
        chk("slew_def", 8'h02, 8'(slw));
        chk("sst_def", 8'h01, 8'(sst));
        chk("addr", 8'(ad[i]), 8'(target_addr));
        chk("code", cd[i], sp_code);
        chk("range", 8'(rg[i]), 8'(rng));
    endtask

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // Tests.
    // ****************************************************************
    initial begin
        #50000;
        mismatches++;
        print_verdict();
    end

    initial begin
        tick(2);
        chk("rst_addr", 8'h40, 8'(target_addr));
        for (int i = 0; i < 12; i++) boot(i);
        strap_set = 6'h3f;
        tick(8);
        chk("hold_addr", 8'h40, 8'(target_addr));
        chk("hold_code", 8'h78, sp_code);
        soft_reset_req = 1'b1;
        tick(1);
        soft_reset_req = 1'b0;
        chk("sreset", 8'h00, 8'(host_ready));
        wait_on(0, 1'b1);
        chk("resample", 8'h44, 8'(target_addr));
        chk("resample_code", 8'h28, sp_code);
        wr(0, 8'h33);
        wr(3, 8'h01);
        wr(2, 8'h03);
        chk("off", 8'h00, 8'(converter_on));
        ext_en = 1'b1;
        wait_on(1, 1'b1);
        chk("start_code", 8'h33, ap_code);
        chk("start_slew", 8'h01, 8'(ap_slw));
        chk("start_sst", 8'h03, 8'(ap_sst));
        chk("ss_on", 8'h01, 8'(ss_active));
        // New range is followed by a setpoint write before it counts.
        wr(1, 8'h02);
        wr(0, 8'h44);
        wr(2, 8'h00);
        chk("ss_code", 8'h33, ap_code);
        chk("ss_range", 8'h03, 8'(ap_rng));
        soft_start_done = 1'b1;
        tick(1);
        soft_start_done = 1'b0;
        tick(1);
        chk("ss_off", 8'h00, 8'(ss_active));
        chk("done_code", 8'h44, ap_code);
        chk("done_range", 8'h02, 8'(ap_rng));
        chk("done_sst", 8'h03, 8'(ap_sst));
        wr(1, 8'h03);
        tick(1);
        chk("range_wait", 8'h02, 8'(ap_rng));
        wr(0, 8'h55);
        tick(1);
        chk("run_code", 8'h55, ap_code);
        chk("run_range", 8'h03, 8'(ap_rng));
        ext_en = 1'b0;
        wait_on(1, 1'b0);
        chk("off_hold", 8'h55, ap_code);
        print_verdict();
    end
endmodule
`default_nettype wire
